//--- rtl/acmp_pkg.sv
/*
 holds the register map, field positions, reset values and shared types of the
 comparator control block. assumes an 8-bit special-function-register bus.
*/
package acmp_pkg;
   // ==========================================================================
   // register addresses
   localparam logic [7:0] ADDR_CTRL = 8'h9B; // comparator_control
   localparam logic [7:0] ADDR_MODE = 8'h9D; // cmp_mode_register
   localparam logic [7:0] ADDR_MUX = 8'h9F; // comparator_input_select
   // ==========================================================================
   // reset values
   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam logic [7:0] RST_MODE = 8'h02;
   localparam logic [7:0] RST_MUX = 8'hFF;
   // ==========================================================================
   // control register bit positions
   localparam int B_EN = 7;
   localparam int B_OUT = 6;
   localparam int B_RIF = 5;
   localparam int B_FIF = 4;
   localparam int B_HYP = 2; // two bits, 3-2
   localparam int B_HYN = 0; // two bits, 1-0
   // mode register bit positions
   localparam int B_RIE = 5;
   localparam int B_FIE = 4;
   localparam int B_MD = 0; // two bits, 1-0
   // mux register bit positions
   localparam int B_NSEL = 4; // four bits, 7-4
   localparam int B_PSEL = 0; // four bits, 3-0
   // ==========================================================================
   // sfr bus request
   typedef struct packed {
      logic wr; // write strobe, one cycle
      logic [7:0] addr; // sfr address
      logic [7:0] wdata; // write data
   } acmp_bus_s;
   // settings sent to the analog core
   typedef struct packed {
      logic enable;
      logic [1:0] pos_hysteresis_sel;
      logic [1:0] neg_hysteresis_sel;
      logic [1:0] response_time_mode;
      logic [3:0] pos_input_sel;
      logic [3:0] neg_input_sel;
   } acmp_analog_s;
endpackage

//--- rtl/acmp_sync.sv
/*
 two-flop synchroniser for the raw comparator level. assumes the level may
 change at any time relative to clk.
*/
`timescale 1ns/100ps
module acmp_sync (
   input wire logic clk,
   input wire logic nrst,
   input wire logic d,
   output logic q
);
   // ==========================================================================
   // state
   typedef struct packed {
      logic s1; // first stage, read only by s2
      logic s2; // second stage, safe to use
   } acmp_sync_s;
   acmp_sync_s st_reg, st_next;

   // next-state: shift the level through
   always_comb begin
      st_next = st_reg;
      st_next.s1 = d;
      st_next.s2 = st_reg.s1;
   end

   // register stage
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign q = st_reg.s2;
endmodule

//--- rtl/acmp_ctrl.sv
/*
 digital control and status around the voltage comparator: control, mode and
 input-select registers on the sfr bus, edge flags and the interrupt request.
 assumes sfr writes are one-cycle strobes and reads are combinational selects
 registered here, so read data appear one cycle after the address.
*/
`timescale 1ns/100ps

// What this block does
// R1 - enable bit powers comparator on and off
// R2 - bit 6 reads current comparator output
// R3 - falling transition sets bit 4 flag
// R4 - rising transition sets bit 5 flag
// R5 - flags sticky until software writes zero
// R6 - rising interrupt only when rising enable set
// R7 - falling interrupt only when falling enable set
// R8 - disabled comparator drives port output low
// R9 - synced output plus raw unclocked output
// R10 - two hysteresis fields, bits 3-2, 1-0
// R11 - bits 7-4 pick negative input pin
// R12 - bits 3-0 pick positive input pin
// R13 - software clears flags after settings change
// R14 - poll, interrupt, pin routing independent
// R15 - mode register: enables, response time, reset 02
// R16 - irq while flag and its enable set
// R17 - edges found on synced output, once each
module acmp_ctrl (
   input wire logic clk,
   input wire logic nrst,
   input wire acmp_pkg::acmp_bus_s sfr_req,
   output logic [7:0] sfr_rdata,
   input wire logic cmp_core_out, // raw analog core decision
   output acmp_pkg::acmp_analog_s analog_cfg,
   output logic synced_cmp_output,
   output logic raw_cmp_output,
   output logic cmp_irq
);
   // ==========================================================================
   // state and helpers
   typedef struct packed {
      logic [7:0] ctrl; // enable, flags, hysteresis (bit 6 not stored)
      logic [7:0] mode; // irq enables and response time
      logic [7:0] mux; // input selects
      logic prev; // previous synced sample
      logic synced; // registered output to port
      logic irq;
      logic [7:0] rdata;
   } acmp_state_s;
   acmp_state_s st_reg, st_next;
   logic cmp_sync; // synchronised core decision
   logic rise, fall;

   // mask write data to its writable bits
   function automatic logic [7:0] acmp_wmask(input logic [7:0] a, input logic [7:0] d);
      case (a)
         acmp_pkg::ADDR_CTRL: acmp_wmask = d & 8'hBF;
         acmp_pkg::ADDR_MODE: acmp_wmask = d & 8'h33;
         default: acmp_wmask = d;
      endcase
   endfunction

   // raw decision is gated by enable; no clock in this path
   assign raw_cmp_output = cmp_core_out & st_reg.ctrl[acmp_pkg::B_EN]; // R8 R9

   acmp_sync u_sync (
      .clk(clk),
      .nrst(nrst),
      .d(raw_cmp_output),
      .q(cmp_sync)
   );

   // edges judged on the synced level, previous vs current sample
   assign rise = cmp_sync & ~st_reg.prev; // R4 R17
   assign fall = ~cmp_sync & st_reg.prev; // R3 R17

   // ==========================================================================
   // next-state logic
   always_comb begin
      st_next = st_reg;
      st_next.prev = cmp_sync;
      // register writes
      if (sfr_req.wr) begin
         case (sfr_req.addr)
            acmp_pkg::ADDR_CTRL: begin
               st_next.ctrl = acmp_wmask(sfr_req.addr, sfr_req.wdata); // R1 R5 R10
            end
            acmp_pkg::ADDR_MODE: begin
               st_next.mode = acmp_wmask(sfr_req.addr, sfr_req.wdata); // R15
            end
            acmp_pkg::ADDR_MUX: begin
               st_next.mux = sfr_req.wdata; // R11 R12
            end
            default: begin
               st_next.mux = st_reg.mux; // other addresses belong elsewhere
            end
         endcase
      end
      // port copy follows the enable being written on this very edge, so a
      // disable pulls the pin low at once instead of after the sync stages;
      // polling and edge flags use the synced copy of the enable-gated raw level
      st_next.synced = cmp_sync & st_next.ctrl[acmp_pkg::B_EN]; // R8 R9 R14
      // hardware sets win over a software clear in the same cycle
      if (rise) begin
         st_next.ctrl[acmp_pkg::B_RIF] = 1'b1; // R4 R5
      end
      if (fall) begin
         st_next.ctrl[acmp_pkg::B_FIF] = 1'b1; // R3 R5
      end
      // interrupt from flags gated by their enables
      st_next.irq = (st_next.ctrl[acmp_pkg::B_RIF] & st_next.mode[acmp_pkg::B_RIE]) |
                    (st_next.ctrl[acmp_pkg::B_FIF] & st_next.mode[acmp_pkg::B_FIE]); // R6 R7 R16
      // read data registered
      case (sfr_req.addr)
         acmp_pkg::ADDR_CTRL: begin
            st_next.rdata = st_reg.ctrl;
            st_next.rdata[acmp_pkg::B_OUT] = cmp_sync; // R2
         end
         acmp_pkg::ADDR_MODE: begin
            st_next.rdata = st_reg.mode;
         end
         acmp_pkg::ADDR_MUX: begin
            st_next.rdata = st_reg.mux;
         end
         default: begin
            st_next.rdata = 8'h00; // unmapped reads as zero
         end
      endcase
   end

   // ==========================================================================
   // state register
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_reg.ctrl <= acmp_pkg::RST_CTRL;
         st_reg.mode <= acmp_pkg::RST_MODE; // R15
         st_reg.mux <= acmp_pkg::RST_MUX;
         st_reg.prev <= 1'b0;
         st_reg.synced <= 1'b0;
         st_reg.irq <= 1'b0;
         st_reg.rdata <= 8'h00;
      end else begin
         st_reg <= st_next;
      end
   end

   // ==========================================================================
   // outputs
   assign sfr_rdata = st_reg.rdata;
   assign synced_cmp_output = st_reg.synced;
   assign cmp_irq = st_reg.irq;
   // analog settings straight from the registers
   assign analog_cfg.enable = st_reg.ctrl[acmp_pkg::B_EN]; // R1
   assign analog_cfg.pos_hysteresis_sel = st_reg.ctrl[acmp_pkg::B_HYP +: 2]; // R10
   assign analog_cfg.neg_hysteresis_sel = st_reg.ctrl[acmp_pkg::B_HYN +: 2]; // R10
   assign analog_cfg.response_time_mode = st_reg.mode[acmp_pkg::B_MD +: 2]; // R15
   assign analog_cfg.pos_input_sel = st_reg.mux[acmp_pkg::B_PSEL +: 4]; // R12
   assign analog_cfg.neg_input_sel = st_reg.mux[acmp_pkg::B_NSEL +: 4]; // R11

   // ==========================================================================
   // assertions
   property p_rise_flag;
      @(posedge clk) disable iff (!nrst) rise |=> st_reg.ctrl[acmp_pkg::B_RIF];
   endproperty
   a_rise_flag: assert property (p_rise_flag) else $error("rise flag not set"); // R4

   property p_fall_flag;
      @(posedge clk) disable iff (!nrst) fall |=> st_reg.ctrl[acmp_pkg::B_FIF];
   endproperty
   a_fall_flag: assert property (p_fall_flag) else $error("fall flag not set"); // R3

   property p_sticky;
      @(posedge clk) disable iff (!nrst)
         st_reg.ctrl[acmp_pkg::B_RIF] && !(sfr_req.wr && sfr_req.addr == acmp_pkg::ADDR_CTRL)
         |=> st_reg.ctrl[acmp_pkg::B_RIF];
   endproperty
   a_sticky: assert property (p_sticky) else $error("rise flag lost"); // R5

   property p_irq_rise;
      @(posedge clk) disable iff (!nrst)
         cmp_irq |-> (st_reg.ctrl[acmp_pkg::B_RIF] && st_reg.mode[acmp_pkg::B_RIE]) ||
                     (st_reg.ctrl[acmp_pkg::B_FIF] && st_reg.mode[acmp_pkg::B_FIE]);
   endproperty
   a_irq_rise: assert property (p_irq_rise) else $error("irq without cause"); // R16

   property p_irq_mask;
      @(posedge clk) disable iff (!nrst)
         !st_reg.mode[acmp_pkg::B_RIE] && !st_reg.mode[acmp_pkg::B_FIE] |-> !cmp_irq;
   endproperty
   a_irq_mask: assert property (p_irq_mask) else $error("irq while masked"); // R6

   property p_irq_fall;
      @(posedge clk) disable iff (!nrst)
         st_reg.ctrl[acmp_pkg::B_FIF] && st_reg.mode[acmp_pkg::B_FIE] |-> cmp_irq;
   endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("fall irq missing"); // R7

   // the port copy is gated on the enable edge itself, so no settling cycles
   property p_off_low;
      @(posedge clk) disable iff (!nrst)
         !st_reg.ctrl[acmp_pkg::B_EN] |-> !synced_cmp_output;
   endproperty
   a_off_low: assert property (p_off_low) else $error("output high while off"); // R8

   // the unclocked copy must also sit low while the core is unpowered
   property p_raw_off;
      @(posedge clk) disable iff (!nrst)
         !st_reg.ctrl[acmp_pkg::B_EN] |-> !raw_cmp_output;
   endproperty
   a_raw_off: assert property (p_raw_off) else $error("raw output high while off"); // R8

   property p_sync_lag;
      @(posedge clk) disable iff (!nrst)
         synced_cmp_output == ($past(cmp_sync) && st_reg.ctrl[acmp_pkg::B_EN]);
   endproperty
   a_sync_lag: assert property (p_sync_lag) else $error("synced output wrong"); // R9

   property p_once;
      @(posedge clk) disable iff (!nrst) rise |=> !rise;
   endproperty
   a_once: assert property (p_once) else $error("edge seen twice"); // R17

   c_rise: cover property (@(posedge clk) disable iff (!nrst) rise);
   c_fall: cover property (@(posedge clk) disable iff (!nrst) fall);
   c_irq: cover property (@(posedge clk) disable iff (!nrst) cmp_irq);
   // disable while the output is high, the case the gating exists for
   c_off: cover property (@(posedge clk) disable iff (!nrst)
      synced_cmp_output ##1 !st_reg.ctrl[acmp_pkg::B_EN]);
endmodule

//--- test/acmp_core_model.sv
/*
 behavioural analog comparator core for the bench.
 assumes the bench sets the input difference and the block supplies the settings.
*/
`timescale 1ns/100ps
module acmp_core_model (
   input wire logic clk,
   input wire acmp_pkg::acmp_analog_s cfg,
   input wire logic vin_above, // bench: positive input above negative
   output logic core_out
);
   // ==========================================================
   // state
   logic slow_reg = 1'b0; // decision seen late in slow modes
   logic junk_reg = 1'b0; // unpowered core has no steady level
   // delay line and junk toggle
   always_ff @(posedge clk) begin
      slow_reg <= vin_above;
      junk_reg <= ~junk_reg;
   end
   // slow modes answer a cycle late, so both speeds get exercised
   assign core_out = !cfg.enable ? junk_reg :
      (cfg.response_time_mode[1] ? slow_reg : vin_above);
endmodule

//--- test/acmp_ctrl_test.sv
/*
 self-checking bench for the comparator control block.
 assumes the sfr bus contract of the block and the core model beside it.
*/
`timescale 1ns/100ps
module acmp_ctrl_test;
   // ==========================================================
   // signals
   logic clk = 1'b0;
   logic nrst = 1'b0;
   acmp_pkg::acmp_bus_s req = '0; // sfr request, driven at falling edge
   logic [7:0] rdata;
   acmp_pkg::acmp_analog_s cfg;
   logic core_out;
   logic synced;
   logic raw;
   logic irq;
   logic vin = 1'b0; // input difference seen by the core
   int err_total = 0;
   int checked = 0;
   // 50 MHz clock
   always #10 clk = ~clk;
   acmp_ctrl dut (.clk(clk), .nrst(nrst), .sfr_req(req), .sfr_rdata(rdata),
      .cmp_core_out(core_out), .analog_cfg(cfg), .synced_cmp_output(synced),
      .raw_cmp_output(raw), .cmp_irq(irq));
   acmp_core_model core (.clk(clk), .cfg(cfg), .vin_above(vin), .core_out(core_out));
   // ==========================================================
   // tasks
   // single compare for every kind of result
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one-cycle write strobe, then a quiet cycle
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      req = '{wr: 1'b1, addr: a, wdata: d};
      @(negedge clk);
      req.wr = 1'b0;
      @(negedge clk);
   endtask
   // data come back one edge after the address
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      req.addr = a;
      @(negedge clk);
      chk({8'h00, rdata}, {8'h00, exp});
   endtask
   // let the sync chain and edge logic settle
   task automatic settle(input logic v);
      vin = v;
      repeat (8) @(negedge clk);
   endtask
   task automatic end_of_test;
      $display("checked %0d err_total %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // ==========================================================
   // watchdog: the tests need well under 300 cycles
   initial begin
      #100000;
      err_total++;
      end_of_test();
   end
   // main sequence
   initial begin
      repeat (4) @(negedge clk);
      nrst = 1'b1;
      rd(acmp_pkg::ADDR_CTRL, 8'h00);
      rd(acmp_pkg::ADDR_MODE, 8'h02);
      chk({14'h0000, cfg.response_time_mode}, 16'h0002);
      rd(acmp_pkg::ADDR_MUX, 8'hFF);
      wr(acmp_pkg::ADDR_MUX, 8'h7A);
      rd(acmp_pkg::ADDR_MUX, 8'h7A);
      chk({8'h00, cfg.neg_input_sel, cfg.pos_input_sel}, 16'h007A);
      wr(acmp_pkg::ADDR_MODE, 8'hFF); // slow response mode
      rd(acmp_pkg::ADDR_MODE, 8'h33);
      chk({14'h0000, cfg.response_time_mode}, 16'h0003);
      wr(acmp_pkg::ADDR_CTRL, 8'hCE); // bit 6 write is ignored
      rd(acmp_pkg::ADDR_CTRL, 8'h8E);
      chk({cfg.enable, cfg.pos_hysteresis_sel, cfg.neg_hysteresis_sel}, 16'h1E);
      wr(acmp_pkg::ADDR_CTRL, 8'h8E);
      settle(1'b1);
      rd(acmp_pkg::ADDR_CTRL, 8'hEE);
      chk({synced, raw, irq}, 16'h7);
      settle(1'b0);
      rd(acmp_pkg::ADDR_CTRL, 8'hBE);
      chk({synced, raw, irq}, 16'h1);
      wr(acmp_pkg::ADDR_MODE, 8'h00); // both masks off, fast mode
      chk(irq, 1'b0);
      wr(acmp_pkg::ADDR_CTRL, 8'h8E);
      settle(1'b1);
      rd(acmp_pkg::ADDR_CTRL, 8'hEE);
      chk({irq, raw, synced}, 16'h3);
      wr(acmp_pkg::ADDR_MODE, 8'h10);
      settle(1'b0);
      chk(irq, 1'b1);
      rd(acmp_pkg::ADDR_CTRL, 8'hBE);
      // output high, then disable: both pin copies must drop at once
      settle(1'b1);
      chk({synced, raw}, 16'h3);
      wr(acmp_pkg::ADDR_CTRL, 8'h0E);
      chk({synced, raw}, 16'h0);
      // core output toggles while unpowered; pins must stay low
      repeat (4) begin
         @(negedge clk);
         chk({synced, raw}, 16'h0);
      end
      rd(8'h00, 8'h00);
      end_of_test();
   end
endmodule
